// file: logic/etls_pkg.sv
// Shared constants for the external torque limit select block
package etls_pkg;
	// Register byte offsets
	localparam logic [7:0] ETLS_OFF_FWD_LIM     = 8'h00;
	localparam logic [7:0] ETLS_OFF_REV_LIM     = 8'h04;
	localparam logic [7:0] ETLS_OFF_FWD_EXT_LIM = 8'h08;
	localparam logic [7:0] ETLS_OFF_REV_EXT_LIM = 8'h0C;
	localparam logic [7:0] ETLS_OFF_CONFIG      = 8'h10;
	localparam logic [7:0] ETLS_OFF_CONTROL     = 8'h14;
	localparam logic [7:0] ETLS_OFF_STATUS      = 8'h18;
	localparam logic [7:0] ETLS_OFF_IRQ_STATUS  = 8'h1C;
	localparam logic [7:0] ETLS_OFF_IRQ_MASK    = 8'h20;
	localparam logic [7:0] ETLS_OFF_MAX_TORQUE  = 8'h24;

	// Limit settings, percent of rated torque
	localparam int         ETLS_LIM_W            = 10;
	localparam logic [9:0] ETLS_LIM_MAX          = 10'h320;
	localparam logic [9:0] ETLS_RST_FWD_LIM      = 10'h320;
	localparam logic [9:0] ETLS_RST_REV_LIM      = 10'h320;
	localparam logic [9:0] ETLS_RST_FWD_EXT_LIM  = 10'h064;
	localparam logic [9:0] ETLS_RST_REV_EXT_LIM  = 10'h064;
	localparam logic [9:0] ETLS_RST_MAX_TORQUE   = 10'h12C;

	// Config field positions
	localparam int ETLS_CFG_ROT_DIR   = 0;
	localparam int ETLS_CFG_ENC_USAGE = 1;
	localparam int ETLS_CFG_FWD_ALLOC = 4;
	localparam int ETLS_CFG_REV_ALLOC = 8;
	localparam int ETLS_CFG_OUT_ALLOC = 12;
	localparam int ETLS_ALLOC_W       = 4;
	localparam logic [15:0] ETLS_RST_CONFIG = 16'h0000;

	// Control, status and interrupt bit positions
	localparam int ETLS_CTL_RESTART   = 0;
	localparam int ETLS_ST_LIMITED    = 0;
	localparam int ETLS_ST_FWD_EXT    = 1;
	localparam int ETLS_ST_REV_EXT    = 2;
	localparam int ETLS_ST_INCR_MODE  = 3;
	localparam int ETLS_ST_POS_VALID  = 4;
	localparam int ETLS_ST_TURNS      = 16;
	localparam int ETLS_IRQ_W         = 3;
	localparam int ETLS_IRQ_LIMITED   = 0;
	localparam int ETLS_IRQ_WRAP_FWD  = 1;
	localparam int ETLS_IRQ_WRAP_REV  = 2;

	// Encoder usage
	typedef enum logic {ETLS_ENC_ABSOLUTE, ETLS_ENC_INCREMENTAL} etls_enc_mode_t;

	// Multiturn count range
	localparam logic signed [15:0] ETLS_TURNS_MAX = 16'sh7FFF;
	localparam logic signed [15:0] ETLS_TURNS_MIN = -16'sh8000;
endpackage

// file: logic/etls_in_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module etls_in_sync import etls_pkg::*; #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// Pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_d;

	// A change counts once stages two and three agree
	assign level_d = (s2_q & s3_q) | (level_out & (s2_q | s3_q));

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s1_q      <= '0;
			s2_q      <= '0;
			s3_q      <= '0;
			level_out <= '0;
		end else begin
			s1_q      <= pin_in;
			s2_q      <= s1_q;
			s3_q      <= s2_q;
			level_out <= level_d;
		end
	end
endmodule

// file: logic/etls_turn_counter.sv
// Signed multiturn rotation counter with wrap-around
`timescale 1ns/1ps
module etls_turn_counter import etls_pkg::*; (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               resetn,
	// Load and step
	input  wire logic               load,
	input  wire logic signed [15:0] load_value,
	input  wire logic               step_fwd,
	input  wire logic               step_rev,
	// Count and wrap events
	output logic signed [15:0]      turns_q,
	output logic                    wrap_fwd,
	output logic                    wrap_rev
);
	logic               at_max;
	logic               at_min;
	logic               do_fwd;
	logic               do_rev;
	logic signed [15:0] turns_d;

	assign at_max   = (turns_q == ETLS_TURNS_MAX);
	assign at_min   = (turns_q == ETLS_TURNS_MIN);
	assign do_fwd   = step_fwd && !step_rev && !load;
	assign do_rev   = step_rev && !step_fwd && !load;
	assign wrap_fwd = do_fwd && at_max;
	assign wrap_rev = do_rev && at_min;

	assign turns_d = load     ? load_value :
			 wrap_fwd ? ETLS_TURNS_MIN :
			 wrap_rev ? ETLS_TURNS_MAX :
			 do_fwd   ? 16'(turns_q + 16'sh0001) :
			 do_rev   ? 16'(turns_q - 16'sh0001) : turns_q;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			turns_q <= '0;
		end else begin
			turns_q <= turns_d;
		end
	end
endmodule

// file: logic/etls_top.sv
// Torque limit selection, encoder usage and multiturn count
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Function
// - forward cap is min of forward limit and forward external limit when asserted
// - reverse cap is min of reverse limit and reverse external limit when asserted
// - each limit setting spans 0 to 800 percent of rated torque, 1% steps
// - defaults 800, 800, 100; limit changes act immediately
// - torque-limited status is active exactly while torque is clipped
// - external limit inputs act only when allocated to a physical input
// - torque-limited status drives a pin only when allocated to an output
// - encoder usage 0 absolute, 1 incremental; change acts after restart
// - multiturn count wraps from +32767 to -32768 going forward
// - multiturn count wraps from -32768 to +32767 going reverse
// - absolute mode provides position right after power-up
// - with direction field 0, positive torque reference is forward
// - limits above motor maximum torque are replaced by the maximum
// - forward and reverse internal limits always apply
module etls_top import etls_pkg::*; #(
	parameter int N_IN  = 8,
	parameter int N_OUT = 4
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               resetn,
	// Register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [31:0]        reg_rdata,
	// Physical discrete inputs and outputs
	input  wire logic [N_IN-1:0]    phys_in,
	output logic      [N_OUT-1:0]   phys_out,
	// Torque reference in percent of rated torque
	input  wire logic signed [11:0] torque_ref,
	output logic signed [11:0]      torque_cmd,
	// Encoder turn steps and power-up absolute turns
	input  wire logic               enc_turn_fwd,
	input  wire logic               enc_turn_rev,
	input  wire logic signed [15:0] enc_abs_turns,
	// Interrupt
	output logic                    irq
);
	// Minimum of two limit values
	function automatic logic [ETLS_LIM_W-1:0] lim_min(input logic [ETLS_LIM_W-1:0] a,
							    input logic [ETLS_LIM_W-1:0] b);
		lim_min = (a < b) ? a : b;
	endfunction

	// Write data saturated to the settable range
	function automatic logic [ETLS_LIM_W-1:0] lim_clamp(input logic [31:0] v);
		lim_clamp = (v > 32'(ETLS_LIM_MAX)) ? ETLS_LIM_MAX : v[ETLS_LIM_W-1:0];
	endfunction

	// Allocation code 0 means unassigned, 1..N selects pin N-1
	function automatic logic alloc_pick(input logic [ETLS_ALLOC_W-1:0] code,
					    input logic [N_IN-1:0] pins);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_IN; i++) begin
			if (code == ETLS_ALLOC_W'(i + 1)) begin
				hit = pins[i];
			end
		end
		alloc_pick = hit;
	endfunction

	// Settings
	logic [ETLS_LIM_W-1:0] fwd_torque_limit_q;
	logic [ETLS_LIM_W-1:0] rev_torque_limit_q;
	logic [ETLS_LIM_W-1:0] fwd_external_torque_limit_q;
	logic [ETLS_LIM_W-1:0] rev_external_torque_limit_q;
	logic [ETLS_LIM_W-1:0] max_torque_q;
	logic [15:0]           config_q;
	logic [ETLS_IRQ_W-1:0] irq_status_q;
	logic [ETLS_IRQ_W-1:0] irq_status_d;
	logic [ETLS_IRQ_W-1:0] irq_mask_q;
	logic [31:0]           reg_rdata_d;
	etls_enc_mode_t        enc_mode_q;
	logic                  pos_valid_q;
	logic                  init_pending_q;
	logic                  torque_limited_q;
	logic                  limited_prev_q;

	// Config fields
	logic                    rotation_direction_select;
	logic                    encoder_usage_select;
	logic [ETLS_ALLOC_W-1:0] fwd_limit_input_alloc;
	logic [ETLS_ALLOC_W-1:0] rev_limit_input_alloc;
	logic [ETLS_ALLOC_W-1:0] limited_output_alloc;

	assign rotation_direction_select = config_q[ETLS_CFG_ROT_DIR];
	assign encoder_usage_select      = config_q[ETLS_CFG_ENC_USAGE];
	assign fwd_limit_input_alloc     = config_q[ETLS_CFG_FWD_ALLOC +: ETLS_ALLOC_W];
	assign rev_limit_input_alloc     = config_q[ETLS_CFG_REV_ALLOC +: ETLS_ALLOC_W];
	assign limited_output_alloc      = config_q[ETLS_CFG_OUT_ALLOC +: ETLS_ALLOC_W];

	// Register decode
	logic wr_fwd;
	logic wr_rev;
	logic wr_fwd_ext;
	logic wr_rev_ext;
	logic wr_cfg;
	logic wr_ctl;
	logic wr_irq_st;
	logic wr_irq_mask;
	logic wr_max;
	logic restart;

	assign wr_fwd      = reg_wr && (reg_addr == ETLS_OFF_FWD_LIM);
	assign wr_rev      = reg_wr && (reg_addr == ETLS_OFF_REV_LIM);
	assign wr_fwd_ext  = reg_wr && (reg_addr == ETLS_OFF_FWD_EXT_LIM);
	assign wr_rev_ext  = reg_wr && (reg_addr == ETLS_OFF_REV_EXT_LIM);
	assign wr_cfg      = reg_wr && (reg_addr == ETLS_OFF_CONFIG);
	assign wr_ctl      = reg_wr && (reg_addr == ETLS_OFF_CONTROL);
	assign wr_irq_st   = reg_wr && (reg_addr == ETLS_OFF_IRQ_STATUS);
	assign wr_irq_mask = reg_wr && (reg_addr == ETLS_OFF_IRQ_MASK);
	assign wr_max      = reg_wr && (reg_addr == ETLS_OFF_MAX_TORQUE);
	assign restart     = wr_ctl && reg_wdata[ETLS_CTL_RESTART];

	// Pin inputs
	logic [N_IN-1:0] pins_lvl;

	etls_in_sync #(
		.WIDTH (N_IN)
	) u_in_sync (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.pin_in    (phys_in),
		.level_out (pins_lvl)
	);

	logic fwd_ext_limit_in;
	logic rev_ext_limit_in;

	assign fwd_ext_limit_in = alloc_pick(fwd_limit_input_alloc, pins_lvl);
	assign rev_ext_limit_in = alloc_pick(rev_limit_input_alloc, pins_lvl);

	// Effective limits per direction
	logic [ETLS_LIM_W-1:0] fwd_sel;
	logic [ETLS_LIM_W-1:0] rev_sel;
	logic [ETLS_LIM_W-1:0] fwd_eff;
	logic [ETLS_LIM_W-1:0] rev_eff;

	// internal forward limit always in force
	assign fwd_sel = fwd_ext_limit_in ?
			 lim_min(fwd_torque_limit_q, fwd_external_torque_limit_q) :
			 fwd_torque_limit_q;
	// internal reverse limit always in force
	assign rev_sel = rev_ext_limit_in ?
			 lim_min(rev_torque_limit_q, rev_external_torque_limit_q) :
			 rev_torque_limit_q;
	assign fwd_eff = lim_min(fwd_sel, max_torque_q);
	assign rev_eff = lim_min(rev_sel, max_torque_q);

	// Clipping
	logic                  ref_neg;
	logic                  ref_fwd;
	logic [11:0]           ref_mag;
	logic [ETLS_LIM_W-1:0] dir_lim;
	logic                  clip;
	logic signed [11:0]    lim_signed;
	logic signed [11:0]    torque_cmd_d;

	assign ref_neg = torque_ref[11];
	// direction field 0 takes positive reference as forward
	assign ref_fwd    = rotation_direction_select ? ref_neg : !ref_neg;
	assign ref_mag    = ref_neg ? 12'(-torque_ref) : 12'(torque_ref);
	assign dir_lim    = ref_fwd ? fwd_eff : rev_eff;
	assign clip       = (ref_mag > 12'(dir_lim));
	assign lim_signed = ref_neg ? 12'(-$signed({2'b00, dir_lim})) : $signed({2'b00, dir_lim});
	assign torque_cmd_d = clip ? lim_signed : torque_ref;

	// Output pins
	logic [N_OUT-1:0] phys_out_d;

	always_comb begin
		phys_out_d = '0;
		for (int i = 0; i < N_OUT; i++) begin
			// status reaches a pin only when allocated
			if (limited_output_alloc == ETLS_ALLOC_W'(i + 1)) begin
				phys_out_d[i] = torque_limited_q;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			phys_out <= '0;
		end else begin
			phys_out <= phys_out_d;
		end
	end

	// Torque command and status
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			torque_cmd       <= '0;
			torque_limited_q <= 1'b0;
			limited_prev_q   <= 1'b0;
		end else begin
			torque_cmd       <= torque_cmd_d;
			// same cycle as the clipped command
			torque_limited_q <= clip;
			limited_prev_q   <= torque_limited_q;
		end
	end

	// Limit settings
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fwd_torque_limit_q          <= ETLS_RST_FWD_LIM;
			rev_torque_limit_q          <= ETLS_RST_REV_LIM;
			fwd_external_torque_limit_q <= ETLS_RST_FWD_EXT_LIM;
			rev_external_torque_limit_q <= ETLS_RST_REV_EXT_LIM;
			max_torque_q                <= ETLS_RST_MAX_TORQUE;
		end else begin
			// writes saturate to the settable range
			// new limits act on the next cycle
			if (wr_fwd) begin
				fwd_torque_limit_q <= lim_clamp(reg_wdata);
			end
			if (wr_rev) begin
				rev_torque_limit_q <= lim_clamp(reg_wdata);
			end
			if (wr_fwd_ext) begin
				fwd_external_torque_limit_q <= lim_clamp(reg_wdata);
			end
			if (wr_rev_ext) begin
				rev_external_torque_limit_q <= lim_clamp(reg_wdata);
			end
			if (wr_max) begin
				max_torque_q <= lim_clamp(reg_wdata);
			end
		end
	end

	// Config and encoder usage
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			config_q   <= ETLS_RST_CONFIG;
			enc_mode_q <= ETLS_ENC_ABSOLUTE;
		end else begin
			if (wr_cfg) begin
				config_q <= reg_wdata[15:0];
			end
			// usage field acts only at restart
			if (restart) begin
				enc_mode_q <= etls_enc_mode_t'(encoder_usage_select);
			end
		end
	end

	// Multiturn count
	logic               turns_load;
	logic signed [15:0] turns_load_val;
	logic signed [15:0] turns_q;
	logic               wrap_fwd;
	logic               wrap_rev;

	// turns loaded on the first cycle after a restart: absolute turns, or zero in incremental mode
	assign turns_load     = init_pending_q;
	assign turns_load_val = (enc_mode_q == ETLS_ENC_ABSOLUTE) ? enc_abs_turns : 16'sh0000;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			init_pending_q <= 1'b1;
			pos_valid_q    <= 1'b0;
		end else begin
			init_pending_q <= restart;
			pos_valid_q    <= !restart && (pos_valid_q || init_pending_q);
		end
	end

	etls_turn_counter u_turns (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.load       (turns_load),
		.load_value (turns_load_val),
		.step_fwd   (enc_turn_fwd),
		.step_rev   (enc_turn_rev),
		.turns_q    (turns_q),
		.wrap_fwd   (wrap_fwd),
		.wrap_rev   (wrap_rev)
	);

	// Interrupts: set wins over write-one-to-clear
	logic [ETLS_IRQ_W-1:0] irq_events;

	assign irq_events[ETLS_IRQ_LIMITED]  = torque_limited_q && !limited_prev_q;
	assign irq_events[ETLS_IRQ_WRAP_FWD] = wrap_fwd;
	assign irq_events[ETLS_IRQ_WRAP_REV] = wrap_rev;
	assign irq_status_d = irq_events |
			      (irq_status_q & ~(wr_irq_st ? reg_wdata[ETLS_IRQ_W-1:0] : '0));
	assign irq = |(irq_status_q & irq_mask_q);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq_status_q <= '0;
			irq_mask_q   <= '0;
		end else begin
			irq_status_q <= irq_status_d;
			if (wr_irq_mask) begin
				irq_mask_q <= reg_wdata[ETLS_IRQ_W-1:0];
			end
		end
	end

	// Read data
	logic [31:0] status_word;

	assign status_word = {turns_q, 11'h000,
			      pos_valid_q,
			      enc_mode_q == ETLS_ENC_INCREMENTAL,
			      rev_ext_limit_in,
			      fwd_ext_limit_in,
			      torque_limited_q};

	always_comb begin
		reg_rdata_d = 32'h0000_0000;
		unique case (reg_addr)
			ETLS_OFF_FWD_LIM:     reg_rdata_d = 32'(fwd_torque_limit_q);
			ETLS_OFF_REV_LIM:     reg_rdata_d = 32'(rev_torque_limit_q);
			ETLS_OFF_FWD_EXT_LIM: reg_rdata_d = 32'(fwd_external_torque_limit_q);
			ETLS_OFF_REV_EXT_LIM: reg_rdata_d = 32'(rev_external_torque_limit_q);
			ETLS_OFF_CONFIG:      reg_rdata_d = 32'(config_q);
			ETLS_OFF_STATUS:      reg_rdata_d = status_word;
			ETLS_OFF_IRQ_STATUS:  reg_rdata_d = 32'(irq_status_q);
			ETLS_OFF_IRQ_MASK:    reg_rdata_d = 32'(irq_mask_q);
			ETLS_OFF_MAX_TORQUE:  reg_rdata_d = 32'(max_torque_q);
			default:              reg_rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? reg_rdata_d : 32'h0000_0000;
		end
	end
endmodule

// file: test/etls_props.sv
// Port checker for the torque limit select block
`timescale 1ns/1ps
module etls_props import etls_pkg::*; #(
	parameter int N_IN  = 8,
	parameter int N_OUT = 4
) (
	// Clock and reset
	input wire logic               core_clk,
	input wire logic               resetn,
	// Register port
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	// Pins
	input wire logic [N_IN-1:0]    phys_in,
	input wire logic [N_OUT-1:0]   phys_out,
	// Torque path
	input wire logic signed [11:0] torque_ref,
	input wire logic signed [11:0] torque_cmd,
	// Encoder and interrupt
	input wire logic               enc_turn_fwd,
	input wire logic               enc_turn_rev,
	input wire logic signed [15:0] enc_abs_turns,
	input wire logic               irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic signed [11:0] ref_q;
	logic [1:0]         age_q;
	logic [3:0]         oal_q;
	wire                clip = torque_cmd != ref_q;
	wire                oal_ok = oal_q != 4'h0 && oal_q <= N_OUT;
	wire [N_OUT-1:0]    pin_exp = oal_ok ? N_OUT'(clip) << (oal_q - 4'h1) : '0;
	// Output mapping is trusted only once the config has settled
	always_ff @(posedge core_clk) begin
		ref_q <= torque_ref;
		if (!resetn) begin
			age_q <= 2'h0;
			oal_q <= 4'h0;
		end else if (reg_wr && reg_addr == ETLS_OFF_CONFIG) begin
			age_q <= 2'h0;
			oal_q <= reg_wdata[ETLS_CFG_OUT_ALLOC +: ETLS_ALLOC_W];
		end else if (age_q != 2'h3) begin
			age_q <= age_q + 2'h1;
		end
	end
	sequence s_mask_clear;
		reg_wr && reg_addr == ETLS_OFF_IRQ_MASK && reg_wdata[ETLS_IRQ_W-1:0] == 3'h0;
	endsequence
	sequence s_quiet_read;
		reg_rd && (reg_addr == ETLS_OFF_CONTROL || reg_addr == 8'h28);
	endsequence
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside answer cycle");
	chk_rst_outputs: assert property (disable iff (1'b0) !resetn |=> reg_rdata == 32'h0
		&& phys_out == '0 && torque_cmd == 12'sh0 && !irq)
		else $error("outputs not cleared by reset");
	chk_cmd_fwd: assert property (torque_ref >= 0 |=> torque_cmd >= 0
		&& torque_cmd <= $past(torque_ref) && torque_cmd <= 12'sh320)
		else $error("positive command out of bounds");
	chk_cmd_rev: assert property (torque_ref < 0 |=> torque_cmd <= 0
		&& torque_cmd >= $past(torque_ref) && torque_cmd >= -12'sh320)
		else $error("negative command out of bounds");
	chk_zero_ref: assert property (torque_ref == 12'sh0 |=> torque_cmd == 12'sh0)
		else $error("zero reference not passed");
	chk_pin_follow: assert property (age_q == 2'h3 |=> phys_out == $past(pin_exp))
		else $error("limited output pin wrong");
	chk_mask_off: assert property (s_mask_clear |=> !irq)
		else $error("irq high with mask clear");
	chk_quiet_read: assert property (s_quiet_read |=> reg_rdata == 32'h0)
		else $error("control or unmapped read not zero");
endmodule
bind etls_top etls_props #(.N_IN(N_IN), .N_OUT(N_OUT)) etls_props_i (.core_clk, .resetn,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phys_in, .phys_out, .torque_ref,
	.torque_cmd, .enc_turn_fwd, .enc_turn_rev, .enc_abs_turns, .irq);

// file: test/etls_host_model.sv
// Host controller model driving the discrete limit inputs
`timescale 1ns/1ps
module etls_host_model import etls_pkg::*; #(
	parameter int N_IN = 8
) (
	// Clock
	input wire logic            core_clk,
	// Requested pin levels
	input wire logic [N_IN-1:0] want,
	// Discrete pins
	output logic [N_IN-1:0]     pins
);
	logic [2:0] hold_q = 3'h0;
	initial pins = '0;
	always @(posedge core_clk) begin
		if (hold_q != 3'h4) begin
			hold_q <= hold_q + 3'h1;
		end else if (want != pins) begin
			pins   <= want;
			hold_q <= 3'h0;
		end
	end
endmodule

// file: test/etls_bench.sv
// Self-checking bench for the torque limit select block
`timescale 1ns/1ps
module etls_bench import etls_pkg::*;;
	logic               core_clk = 1'b0;
	logic               resetn = 1'b0;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0, reg_rdata, m;
	logic               reg_wr = 1'b0, reg_rd = 1'b0, irq;
	logic [7:0]         want = 8'h00, phys_in, v;
	logic [3:0]         phys_out;
	logic signed [11:0] torque_ref = 12'sh0, torque_cmd, r;
	logic               enc_turn_fwd = 1'b0, enc_turn_rev = 1'b0;
	logic signed [15:0] enc_abs_turns = 16'sh1234;
	logic               ref_stb = 1'b0;
	int                 num_errors = 0, check_count = 0, cyc = 0;
	int                 lim[10];
	bit                 fa, ra, dir, fen, ren, rd_d, ref_d;
	logic [31:0]        rdq[$], rmq[$];
	logic signed [11:0] tq[$];

	always #2.5 core_clk = ~core_clk;

	etls_top #(.N_IN(8), .N_OUT(4)) etls_top_i (.core_clk, .resetn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .phys_in, .phys_out, .torque_ref, .torque_cmd,
		.enc_turn_fwd, .enc_turn_rev, .enc_abs_turns, .irq);
	etls_host_model #(.N_IN(8)) etls_host_model_i (.core_clk, .want, .pins(phys_in));

	task automatic test_done();
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] mk);
		@(posedge core_clk);
		rdq.push_back(e & mk);
		rmq.push_back(mk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	// Settings above 800 saturate
	task automatic wl(int i, int d);
		wr(8'(4 * i), 32'(d));
		lim[i] = d > 800 ? 800 : d;
	endtask

	function automatic logic signed [11:0] exp_cmd(int x);
		int l;
		int a;
		bit f;
		f = dir ? x < 0 : x >= 0;
		l = f ? (fa && lim[2] < lim[0] ? lim[2] : lim[0]) : (ra && lim[3] < lim[1] ? lim[3] : lim[1]);
		if (l > lim[9]) l = lim[9];
		a = x < 0 ? -x : x;
		if (a > l) a = l;
		return 12'(x < 0 ? -a : a);
	endfunction

	task automatic drv(logic signed [11:0] x);
		@(posedge core_clk);
		torque_ref <= x;
		ref_stb    <= 1'b1;
		tq.push_back(exp_cmd(x));
		@(posedge core_clk);
		ref_stb <= 1'b0;
		rd(ETLS_OFF_STATUS, {29'h0, ra, fa, exp_cmd(x) != x}, 32'h7);
	endtask

	task automatic cfg(bit inc, logic [3:0] oa);
		wr(ETLS_OFF_CONFIG, {16'h0, oa, 2'h0, ren, 1'b0, 3'h0, fen, 2'h0, inc, dir});
	endtask

	task automatic step(bit f);
		@(posedge core_clk);
		enc_turn_fwd <= f;
		enc_turn_rev <= !f;
		@(posedge core_clk);
		enc_turn_fwd <= 1'b0;
		enc_turn_rev <= 1'b0;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (rd_d) begin
			m = rmq.pop_front();
			chk("reg_rdata", rdq.pop_front(), reg_rdata & m);
		end
		if (ref_d) chk("torque_cmd", 32'(tq.pop_front()), 32'(torque_cmd));
		rd_d = reg_rd;
		ref_d = ref_stb;
		if (cyc == 30000) begin
			num_errors++;
			test_done();
		end
	end

	initial begin
		void'($urandom(14));
		lim = '{800, 800, 100, 100, 0, 0, 0, 0, 0, 300};
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		foreach (lim[i]) if (i < 4 || i == 9) rd(8'(4 * i), lim[i], 32'hFFFFFFFF);
		rd(ETLS_OFF_STATUS, 32'h12340010, 32'hFFFF0018);
		rd(8'h28, 32'h0, 32'hFFFFFFFF);
		drv(12'sh384);
		drv(-12'sh384);
		repeat (40) begin
			for (int i = 0; i < 4; i++) wl(i, $urandom_range(0, 850));
			wl(9, $urandom_range(0, 850));
			rd(8'h00, lim[0], 32'hFFFFFFFF);
			v = 8'($urandom());
			{dir, fen, ren} = 3'($urandom());
			@(posedge core_clk);
			want <= v;
			fa = fen & v[0];
			ra = ren & v[1];
			cfg(1'b0, 4'($urandom_range(0, 5)));
			repeat (12) @(posedge core_clk);
			r = 12'($urandom_range(0, 2000) - 1000);
			drv(r);
			wl(0, $urandom_range(0, 800));
			wl(1, $urandom_range(0, 800));
			drv(r);
		end
		wr(ETLS_OFF_IRQ_MASK, 32'h6);
		enc_abs_turns <= 16'sh7FFF;
		wr(ETLS_OFF_CONTROL, 32'h1);
		repeat (4) @(posedge core_clk);
		rd(ETLS_OFF_STATUS, 32'h7FFF0010, 32'hFFFF0018);
		step(1'b1);
		rd(ETLS_OFF_STATUS, 32'h80000000, 32'hFFFF0000);
		step(1'b0);
		rd(ETLS_OFF_STATUS, 32'h7FFF0000, 32'hFFFF0000);
		rd(ETLS_OFF_IRQ_STATUS, 32'h6, 32'h6);
		#1 chk("irq", 32'h1, 32'(irq));
		wr(ETLS_OFF_IRQ_STATUS, 32'h6);
		rd(ETLS_OFF_IRQ_STATUS, 32'h0, 32'h6);
		#1 chk("irq", 32'h0, 32'(irq));
		step(1'b1);
		wr(ETLS_OFF_IRQ_MASK, 32'h0);
		#1 chk("irq", 32'h0, 32'(irq));
		cfg(1'b1, 4'h1);
		rd(ETLS_OFF_STATUS, 32'h0, 32'h8);
		wr(ETLS_OFF_CONTROL, 32'h1);
		repeat (4) @(posedge core_clk);
		rd(ETLS_OFF_STATUS, 32'h00000018, 32'hFFFF0018);
		rd(ETLS_OFF_CONTROL, 32'h0, 32'hFFFFFFFF);
		repeat (3) @(posedge core_clk);
		test_done();
	end
endmodule
